// *** rtl/can_buf_pkg.sv ***
// Shared constants, types and helpers of the CAN message buffer block
package can_buf_pkg;
  localparam int BUF_BYTES = 13;
  localparam int TX_BUFS   = 3;
  localparam int LOCAL_PRIORITY_FIELD_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int IDX_W     = 4;
  localparam int SEL_W     = 2;
  localparam int WORD_LSB  = 2;
  localparam logic [ADDR_W-1:0] OFS_RX_BUF    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RX_FLAG   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TX_FLAG   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TX_CTRL   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MODE      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_TX_LOCAL_PRIORITY_FIELD   = 8'h20;
  localparam logic [ADDR_W-1:0] LOCAL_PRIORITY_FIELD_STRIDE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TX_BUF    = 8'h40;
  localparam logic [ADDR_W-1:0] TX_BUF_STRIDE = 8'h10;
  localparam int RX_FULL_BIT   = 0;
  localparam int OVR_BIT       = 1;
  localparam int EMPTY_LSB     = 0;
  localparam int ABORT_ACK_LSB = 4;
  localparam int ABORT_REQ_LSB = 0;
  localparam int TXIE_LSB  = 4;
  localparam int LOOP_BIT  = 0;
  localparam int RXIE_BIT  = 1;
  localparam int OVRIE_BIT = 2;
  localparam logic [TX_BUFS-1:0] EMPTY_RESET = 3'h7;
  localparam logic [LOCAL_PRIORITY_FIELD_W-1:0]  LOCAL_PRIORITY_FIELD_RESET = 8'h00;
  typedef logic [BUF_BYTES-1:0][7:0] frame_t;
  typedef logic [TX_BUFS-1:0]        txmask_t;
  typedef logic [TX_BUFS-1:0][LOCAL_PRIORITY_FIELD_W-1:0] local_priority_field_set_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_t;

  // Bytes past the end of a buffer read as zero
  function automatic logic [31:0] word_of(input frame_t f, input logic [1:0] w);
    logic [31:0] r;
    int          k;
    r = 32'h0;
    for (int l = 0; l < 4; l++) begin
      k = 4 * int'(w) + l;
      if (k < BUF_BYTES) r[8*l +: 8] = f[k];
    end
    return r;
  endfunction : word_of
endpackage : can_buf_pkg

// *** rtl/can_buf_links.sv ***
// Internal links between the buffer top and its receive and scheduling parts
`timescale 1ns/1ps
interface rx_link_if;
  import can_buf_pkg::*;
  logic             wr;
  logic [IDX_W-1:0] idx;
  logic [7:0]       data;
  logic             eof_ok;
  logic             id_match;
  logic             own;
  logic             full_clr;
  logic             full;
  logic             hold;
  logic             ovr_evt;
  frame_t           fg;
  modport core  (output wr, idx, data, eof_ok, id_match, own, full_clr,
                 input full, hold, ovr_evt, fg);
  modport store (input wr, idx, data, eof_ok, id_match, own, full_clr,
                 output full, hold, ovr_evt, fg);
endinterface : rx_link_if

interface tx_link_if;
  import can_buf_pkg::*;
  txmask_t          pending;
  local_priority_field_set_t        local_priority_field;
  logic             arb;
  logic [SEL_W-1:0] sel;
  logic             sel_ok;
  modport core  (output pending, local_priority_field, arb, input sel, sel_ok);
  modport sched (input pending, local_priority_field, arb, output sel, sel_ok);
endinterface : tx_link_if

// *** rtl/rx_two_stage.sv ***
// Two-stage receive store: background capture buffer and foreground CPU buffer
`timescale 1ns/1ps
module rx_two_stage (
  input wire logic core_clk,
  input wire logic rst_n,
  rx_link_if.store L
);
  import can_buf_pkg::*;

  typedef struct packed {
    frame_t bg;
    frame_t fg;
    logic   full;
    logic   hold;
    logic   ovr_evt;
  } rx_state_t;

  rx_state_t st;
  rx_state_t next_st;
  logic      accept;

  assign accept = L.eof_ok && L.id_match && !L.own;

  always_comb begin
    next_st = st;
    next_st.ovr_evt = 1'b0;
    // A held frame locks the background buffer, so later frames are dropped
    if (L.wr && !st.hold && L.idx < IDX_W'(BUF_BYTES)) begin
      next_st.bg[L.idx] = L.data;
    end
    if (accept) begin
      if (!st.full) begin
        next_st.fg   = st.bg;
        next_st.full = 1'b1;
      end else if (!st.hold) begin
        next_st.hold = 1'b1;
      end else begin
        next_st.ovr_evt = 1'b1;
      end
    end else if (L.full_clr && st.full) begin
      // Clear is refused while a second frame waits; it moves up instead
      if (st.hold) begin
        next_st.fg   = st.bg;
        next_st.hold = 1'b0;
      end else begin
        next_st.full = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign L.full    = st.full;
  assign L.hold    = st.hold;
  assign L.ovr_evt = st.ovr_evt;
  assign L.fg      = st.fg;

  property p_copy;
    @(posedge core_clk) disable iff (!rst_n)
      accept && !st.full |=> st.full && st.fg == $past(st.bg);
  endproperty
  a_copy: assert property (p_copy) else $error("accepted frame not copied");

  property p_ovr;
    @(posedge core_clk) disable iff (!rst_n)
      accept && st.full && st.hold |=> st.ovr_evt && $stable(st.fg) ##1 !st.ovr_evt;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_own;
    @(posedge core_clk) disable iff (!rst_n)
      L.eof_ok && L.own |=> $stable(st.fg) && $stable(st.full);
  endproperty
  a_own: assert property (p_own) else $error("own frame reached foreground");

  property p_clr;
    @(posedge core_clk) disable iff (!rst_n)
      L.full_clr && st.full && st.hold && !accept |=> st.full && !st.hold;
  endproperty
  a_clr: assert property (p_clr) else $error("refused clear mishandled");
endmodule : rx_two_stage

// *** rtl/tx_select.sv ***
// Picks the pending transmit buffer with the lowest priority value
`timescale 1ns/1ps
module tx_select (
  input wire logic  core_clk,
  input wire logic  rst_n,
  tx_link_if.sched L
);
  import can_buf_pkg::*;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic             ok;
  } sel_state_t;

  sel_state_t st;
  sel_state_t next_st;

  // Strict compare: equal priorities go to the lower buffer number
  function automatic logic [SEL_W-1:0] pick(input txmask_t p, input local_priority_field_set_t pr);
    logic [SEL_W-1:0] b;
    logic             found;
    b     = '0;
    found = 1'b0;
    for (int i = 0; i < TX_BUFS; i++) begin
      if (p[i] && (!found || pr[i] < pr[b])) begin
        b     = SEL_W'(i);
        found = 1'b1;
      end
    end
    return b;
  endfunction : pick

  always_comb begin
    next_st = st;
    if (L.arb) begin
      next_st.sel = pick(L.pending, L.local_priority_field);
      next_st.ok  = |L.pending;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign L.sel    = st.sel;
  assign L.sel_ok = st.ok;

  property p_sel;
    @(posedge core_clk) disable iff (!rst_n)
      L.arb |=> L.sel_ok == |$past(L.pending);
  endproperty
  a_sel: assert property (p_sel) else $error("selection not refreshed");
endmodule : tx_select

// *** rtl/can_msg_buffers.sv ***
// Message storage of a CAN controller: receive FIFO, transmit buffers, registers
//
// Overview of operation
// - Received frames pass a two-stage FIFO; only the foreground buffer is visible.
// - Each receive buffer stores 13 bytes of control, identifier and data.
// - rx_full_flag is set while the foreground holds an accepted good frame.
// - Incoming bytes go to the background buffer while the filter decides.
// - Accepted frame with flag clear is copied forward, flag set, interrupt raised.
// - Background buffer takes the next frame right away, filter or not.
// - Own transmitted frames only reach the background buffer; no acknowledge.
// - Loop-back treats own frames like any other received frame.
// - After lost arbitration the winning frame is received normally.
// - Accepted frame with both buffers full is dropped and overrun flagged.
// - With both buffers full, transmission continues and incoming frames drop.
// - Three transmit buffers, each with an 8-bit local priority register.
// - Successful send sets tx_empty_flag and raises the transmit interrupt.
// - The pending buffer with the smallest priority value goes first.
// - Buffer selection repeats at every arbitration, also after errors.
// - Abort of a buffer not on the bus sets ack and empty flags.
// - abort_ack_flag ends at 1 when aborted, at 0 when sent instead.
// - Flags clear by writing one; a clear is ignored while its cause stays.
// - can_tx_pin is low for dominant and high for recessive.
// - Receive interrupt follows the end of frame of an accepted frame.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module can_msg_buffers (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic [can_buf_pkg::ADDR_W-1:0] address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  input  wire logic [3:0]                   byteenable,
  output logic      [31:0]                  readdata,
  output logic                              waitrequest,
  input  wire logic                         can_rx_pin,
  output logic                              can_tx_pin,
  output logic                              rx_level,
  input  wire logic                         tx_dominant,
  input  wire logic                         rx_wr,
  input  wire logic [can_buf_pkg::IDX_W-1:0] rx_idx,
  input  wire logic [7:0]                   rx_byte,
  input  wire logic                         rx_eof_ok,
  input  wire logic                         rx_id_match,
  input  wire logic                         tx_active,
  output logic                              ack_enable,
  input  wire logic                         arb_req,
  output logic      [can_buf_pkg::SEL_W-1:0] tx_sel,
  output logic                              tx_sel_valid,
  input  wire logic [can_buf_pkg::IDX_W-1:0] tx_rd_idx,
  output logic      [7:0]                   tx_rd_byte,
  input  wire logic                         tx_ok,
  output logic                              rx_irq,
  output logic                              tx_irq,
  output logic                              err_irq
);
  import can_buf_pkg::*;

  typedef struct packed {
    bus_state_t                     bus;
    logic [31:0]                    rdata;
    logic [TX_BUFS-1:0][BUF_BYTES-1:0][7:0] txb;
    local_priority_field_set_t                      local_priority_field;
    txmask_t                        empty;
    txmask_t                        abort_req;
    txmask_t                        abort_ack;
    txmask_t                        txie;
    logic                           loop;
    logic                           rxie;
    logic                           ovrie;
    logic                           ovr;
    logic                           txpin;
    logic                           rxs0;
    logic                           rxs1;
    logic [7:0]                     txbyte;
  } top_state_t;

  top_state_t       st;
  top_state_t       next_st;
  logic [1:0]       rst_pipe;
  logic             rst_sync_n;
  logic             wr_go;
  logic             tb_hit;
  logic             pr_hit;
  logic [ADDR_W-1:0] tb_off;
  logic [ADDR_W-1:0] pr_off;
  logic [SEL_W-1:0] tb;
  logic [SEL_W-1:0] pi;
  logic [1:0]       wsel;
  logic [31:0]      rd_word;
  logic             rx_clr;
  logic             ovr_clr;
  txmask_t          empty_clr;
  txmask_t          abt_wr;
  txmask_t          onbus;
  txmask_t          ok_set;
  txmask_t          grant;
  txmask_t          empty_set;
  int               k;

  rx_link_if rl ();
  tx_link_if tl ();

  // Reset is asserted at once but released only after two clean edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  assign rl.wr       = rx_wr;
  assign rl.idx      = rx_idx;
  assign rl.data     = rx_byte;
  assign rl.eof_ok   = rx_eof_ok;
  assign rl.id_match = rx_id_match;
  assign rl.own      = tx_active && !st.loop;
  assign rl.full_clr = rx_clr;

  assign tl.pending = ~st.empty;
  assign tl.local_priority_field    = st.local_priority_field;
  assign tl.arb     = arb_req;

  rx_two_stage u_rx (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .L        (rl.store)
  );

  tx_select u_sel (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .L        (tl.sched)
  );

  always_comb begin
    next_st = st;
    k       = 0;
    tb_off  = address - OFS_TX_BUF;
    pr_off  = address - OFS_TX_LOCAL_PRIORITY_FIELD;
    tb_hit  = address >= OFS_TX_BUF && tb_off < ADDR_W'(TX_BUFS) * TX_BUF_STRIDE;
    pr_hit  = address >= OFS_TX_LOCAL_PRIORITY_FIELD && pr_off < ADDR_W'(TX_BUFS) * LOCAL_PRIORITY_FIELD_STRIDE;
    tb      = SEL_W'(tb_off / TX_BUF_STRIDE);
    pi      = SEL_W'(pr_off / LOCAL_PRIORITY_FIELD_STRIDE);
    wsel    = address[WORD_LSB +: 2];
    wr_go   = write && st.bus == BUS_ACK;

    // One wait state: the answer is prepared while waitrequest is high
    case (st.bus)
      BUS_IDLE: begin
        if (read || write) next_st.bus = BUS_ACK;
      end
      BUS_ACK: next_st.bus = BUS_IDLE;
      default: next_st.bus = BUS_IDLE;
    endcase

    rd_word = 32'h0;
    if (address < OFS_RX_FLAG) begin
      rd_word = word_of(rl.fg, wsel);
    end else if (address == OFS_RX_FLAG) begin
      rd_word[RX_FULL_BIT] = rl.full;
      rd_word[OVR_BIT]     = st.ovr;
    end else if (address == OFS_TX_FLAG) begin
      rd_word[EMPTY_LSB +: TX_BUFS]     = st.empty;
      rd_word[ABORT_ACK_LSB +: TX_BUFS] = st.abort_ack;
    end else if (address == OFS_TX_CTRL) begin
      rd_word[ABORT_REQ_LSB +: TX_BUFS] = st.abort_req;
      rd_word[TXIE_LSB +: TX_BUFS]  = st.txie;
    end else if (address == OFS_MODE) begin
      rd_word[LOOP_BIT]  = st.loop;
      rd_word[RXIE_BIT]  = st.rxie;
      rd_word[OVRIE_BIT] = st.ovrie;
    end else if (tb_hit) begin
      rd_word = word_of(st.txb[tb], wsel);
    end else if (pr_hit) begin
      rd_word[LOCAL_PRIORITY_FIELD_W-1:0] = st.local_priority_field[pi];
    end
    if (read && st.bus == BUS_IDLE) next_st.rdata = rd_word;

    rx_clr    = 1'b0;
    ovr_clr   = 1'b0;
    empty_clr = '0;
    abt_wr    = '0;
    if (wr_go && byteenable[0]) begin
      case (address)
        OFS_RX_FLAG: begin
          rx_clr  = writedata[RX_FULL_BIT];
          ovr_clr = writedata[OVR_BIT];
        end
        OFS_TX_FLAG: empty_clr = writedata[EMPTY_LSB +: TX_BUFS];
        OFS_TX_CTRL: begin
          abt_wr       = writedata[ABORT_REQ_LSB +: TX_BUFS];
          next_st.txie = writedata[TXIE_LSB +: TX_BUFS];
        end
        OFS_MODE: begin
          next_st.loop  = writedata[LOOP_BIT];
          next_st.rxie  = writedata[RXIE_BIT];
          next_st.ovrie = writedata[OVRIE_BIT];
        end
        default: ;
      endcase
      if (pr_hit) next_st.local_priority_field[pi] = writedata[LOCAL_PRIORITY_FIELD_W-1:0];
    end
    if (wr_go && tb_hit) begin
      for (int l = 0; l < 4; l++) begin
        k = 4 * int'(wsel) + l;
        if (k < BUF_BYTES && byteenable[l]) next_st.txb[tb][k] = writedata[8*l +: 8];
      end
    end

    // The buffer on the bus cannot be aborted meanwhile, though its bytes can still be written
    onbus  = '0;
    ok_set = '0;
    if (tx_active && tl.sel_ok) onbus[tl.sel] = 1'b1;
    if (tx_ok && tl.sel_ok) ok_set[tl.sel] = 1'b1;
    grant     = st.abort_req & ~st.empty & ~onbus;
    empty_set = ok_set | grant;
    // Hardware set wins over a software clear in the same cycle
    next_st.empty     = (st.empty & ~empty_clr) | empty_set;
    next_st.abort_ack = (st.abort_ack & ~empty_clr & ~ok_set) | grant;
    next_st.abort_req = (st.abort_req | (abt_wr & ~st.empty)) & ~empty_set;
    next_st.ovr       = (st.ovr & ~ovr_clr) | rl.ovr_evt;

    next_st.txbyte = 8'h00;
    if (tx_rd_idx < IDX_W'(BUF_BYTES)) next_st.txbyte = st.txb[tl.sel][tx_rd_idx];
    next_st.txpin = !tx_dominant;
    next_st.rxs0  = can_rx_pin;
    next_st.rxs1  = st.rxs0;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st       <= '0;
      st.bus   <= BUS_IDLE;
      st.empty <= EMPTY_RESET;
      st.local_priority_field  <= {TX_BUFS{LOCAL_PRIORITY_FIELD_RESET}};
      st.txpin <= 1'b1;
      st.rxs0  <= 1'b1;
      st.rxs1  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign waitrequest  = (read || write) && st.bus != BUS_ACK;
  assign readdata     = st.rdata;
  assign can_tx_pin   = st.txpin;
  assign rx_level     = st.rxs1;
  assign ack_enable   = !rl.own;
  assign tx_sel       = tl.sel;
  assign tx_sel_valid = tl.sel_ok;
  assign tx_rd_byte   = st.txbyte;
  assign rx_irq       = rl.full && st.rxie;
  assign tx_irq       = |(st.empty & st.txie);
  assign err_irq      = st.ovr && st.ovrie;

  property p_empty_ok;
    @(posedge core_clk) disable iff (!rst_sync_n)
      tx_ok && tl.sel_ok |=> st.empty[$past(tl.sel)] && !st.abort_ack[$past(tl.sel)];
  endproperty
  a_empty_ok: assert property (p_empty_ok) else $error("sent buffer not released");

  property p_no_abort_onbus;
    @(posedge core_clk) disable iff (!rst_sync_n)
      tx_active && tl.sel_ok && !tx_ok && !st.empty[tl.sel] |=> !st.empty[$past(tl.sel)];
  endproperty
  a_no_abort_onbus: assert property (p_no_abort_onbus) else $error("frame on bus freed");

  property p_grant;
    @(posedge core_clk) disable iff (!rst_sync_n)
      st.abort_req[0] && !st.empty[0] && !onbus[0]
        |=> st.empty[0] && st.abort_ack[0] && !st.abort_req[0];
  endproperty
  a_grant: assert property (p_grant) else $error("abort not granted");

  property p_req_drop;
    @(posedge core_clk) disable iff (!rst_sync_n)
      $rose(st.empty[1]) |-> !st.abort_req[1];
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("abort request left pending");

  property p_pin;
    @(posedge core_clk) disable iff (!rst_sync_n)
      tx_dominant ##1 tx_dominant |=> !can_tx_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("dominant not driven low");

  property p_rx_irq;
    @(posedge core_clk) disable iff (!rst_sync_n)
      rx_eof_ok && rx_id_match && !rl.own && !rl.full && st.rxie |=> rx_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt late");

  property p_ovr_flag;
    @(posedge core_clk) disable iff (!rst_sync_n)
      rl.ovr_evt |=> st.ovr;
  endproperty
  a_ovr_flag: assert property (p_ovr_flag) else $error("overrun flag lost");
endmodule : can_msg_buffers

// *** tb/can_engine_model.sv ***
// Stand-in for the protocol engine and the bus behind the message buffers
`timescale 1ns/1ps
module can_engine_model (
  input  wire logic                          core_clk,
  output logic                               can_rx_pin,
  output logic                               tx_dominant,
  output logic                               rx_wr,
  output logic [can_buf_pkg::IDX_W-1:0]      rx_idx,
  output logic [7:0]                         rx_byte,
  output logic                               rx_eof_ok,
  output logic                               rx_id_match,
  output logic                               tx_active,
  output logic                               arb_req,
  output logic [can_buf_pkg::IDX_W-1:0]      tx_rd_idx,
  output logic                               tx_ok
);
  // Bus idles recessive; only our own dominant bits pull it low
  assign can_rx_pin = ~tx_dominant;
  initial begin
    {tx_dominant, rx_wr, rx_eof_ok, rx_id_match, tx_active, arb_req, tx_ok} = '0;
    {rx_idx, rx_byte, tx_rd_idx} = '0;
  end
  // One frame of 13 bytes, then end of frame; ta1 low models lost arbitration
  task automatic frame(input logic [7:0] s, input logic m, input logic ta0, input logic ta1);
    @(posedge core_clk);
    tx_active <= ta0;
    for (int k = 0; k < 13; k++) begin
      rx_wr   <= 1'b1;
      rx_idx  <= 4'(k);
      rx_byte <= s + 8'(k);
      @(posedge core_clk);
    end
    rx_wr       <= 1'b0;
    rx_byte     <= ~rx_byte;
    tx_active   <= ta1;
    rx_eof_ok   <= 1'b1;
    rx_id_match <= m;
    @(posedge core_clk);
    rx_eof_ok   <= 1'b0;
    rx_id_match <= ~m;
    tx_active   <= 1'b0;
  endtask : frame
  task automatic arb(input logic [3:0] i);
    @(posedge core_clk);
    arb_req   <= 1'b1;
    tx_rd_idx <= i;
    @(posedge core_clk);
    arb_req   <= 1'b0;
    tx_active <= 1'b1;
  endtask : arb
  task automatic sent;
    @(posedge core_clk);
    tx_ok <= 1'b1;
    @(posedge core_clk);
    tx_ok     <= 1'b0;
    tx_active <= 1'b0;
  endtask : sent
  // Bus level requested by the engine, changed just after a rising edge
  task automatic dom(input logic d);
    @(posedge core_clk);
    tx_dominant <= d;
  endtask : dom
endmodule : can_engine_model

// *** tb/can_message_buffers_tb.sv ***
// Self-checking bench of the CAN message buffers
`timescale 1ns/1ps
module can_message_buffers_tb;
  import can_buf_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
  logic        core_clk, rst_n, read, write, waitrequest, can_rx_pin, can_tx_pin, rx_level;
  logic        tx_dominant, rx_wr, rx_eof_ok, rx_id_match, tx_active, ack_enable, arb_req;
  logic        tx_sel_valid, tx_ok, rx_irq, tx_irq, err_irq;
  logic [7:0]  address, rx_byte, tx_rd_byte;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable, rx_idx, tx_rd_idx;
  logic [1:0]  tx_sel;
  int          errors, cmp_count, cycles;
  row_t rows [16] = '{
    '{8'h10, 1'b0, 32'h0, 32'h0},
    '{8'h14, 1'b0, 32'h0, 32'h7},
    '{8'h18, 1'b0, 32'h0, 32'h0},
    '{8'h1C, 1'b0, 32'h0, 32'h0},
    '{8'h20, 1'b1, 32'h30, 32'h0},
    '{8'h20, 1'b0, 32'h0, 32'h30},
    '{8'h24, 1'b1, 32'h10, 32'h0},
    '{8'h24, 1'b0, 32'h0, 32'h10},
    '{8'h28, 1'b1, 32'h20, 32'h0},
    '{8'h28, 1'b0, 32'h0, 32'h20},
    '{8'h54, 1'b1, 32'hA5A5A5A5, 32'h0},
    '{8'h54, 1'b0, 32'h0, 32'hA5A5A5A5},
    '{8'h80, 1'b1, 32'hFF, 32'h0},
    '{8'h80, 1'b0, 32'h0, 32'h0},
    '{8'h00, 1'b1, 32'hFF, 32'h0},
    '{8'h00, 1'b0, 32'h0, 32'h0}};
  can_msg_buffers dut_u (.core_clk(core_clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .can_rx_pin(can_rx_pin),
    .can_tx_pin(can_tx_pin), .rx_level(rx_level), .tx_dominant(tx_dominant),
    .rx_wr(rx_wr), .rx_idx(rx_idx), .rx_byte(rx_byte), .rx_eof_ok(rx_eof_ok),
    .rx_id_match(rx_id_match), .tx_active(tx_active), .ack_enable(ack_enable),
    .arb_req(arb_req), .tx_sel(tx_sel), .tx_sel_valid(tx_sel_valid),
    .tx_rd_idx(tx_rd_idx), .tx_rd_byte(tx_rd_byte), .tx_ok(tx_ok),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .err_irq(err_irq));
  can_engine_model eng_u (.core_clk(core_clk), .can_rx_pin(can_rx_pin),
    .tx_dominant(tx_dominant), .rx_wr(rx_wr), .rx_idx(rx_idx), .rx_byte(rx_byte),
    .rx_eof_ok(rx_eof_ok), .rx_id_match(rx_id_match), .tx_active(tx_active),
    .arb_req(arb_req), .tx_rd_idx(tx_rd_idx), .tx_ok(tx_ok));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Run is about 270 cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Request held until the edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    if (n >= 20) errors++;
  endtask : xfer
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  task automatic nx(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : nx
  // Expected foreground word: byte k of a frame is seed plus k, past byte 12 zero
  function automatic logic [31:0] fw(input logic [7:0] s, input int w);
    logic [31:0] r = '0;
    for (int l = 0; l < 4; l++)
      if (4 * w + l < 13) r[8*l +: 8] = s + 8'(4 * w + l);
    return r;
  endfunction : fw
  initial begin
    {rst_n, read, write, address, writedata} = '0;
    byteenable = 4'hF;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].e);
    end
    $display("test register table done");
    xfer(1'b1, 8'h1C, 32'h6);
    eng_u.frame(8'h10, 1'b1, 1'b0, 1'b0);
    nx(0);
    chk(32'(rx_irq), 32'h1);
    for (int w = 0; w < 4; w++) rc(8'(4 * w), fw(8'h10, w));
    eng_u.frame(8'h50, 1'b0, 1'b0, 1'b0);
    eng_u.frame(8'h30, 1'b1, 1'b0, 1'b0);
    eng_u.frame(8'h70, 1'b1, 1'b0, 1'b0);
    nx(2);
    chk(32'(err_irq), 32'h1);
    rc(8'h00, fw(8'h10, 0));
    xfer(1'b1, 8'h10, 32'h1);
    rc(8'h10, 32'h3);
    rc(8'h00, fw(8'h30, 0));
    xfer(1'b1, 8'h10, 32'h3);
    rc(8'h10, 32'h0);
    chk(32'({rx_irq, err_irq}), 32'h0);
    $display("test receive fifo done");
    eng_u.frame(8'h20, 1'b1, 1'b1, 1'b1);
    nx(1);
    chk(32'(rx_irq), 32'h0);
    eng_u.frame(8'h40, 1'b1, 1'b1, 1'b0);
    rc(8'h00, fw(8'h40, 0));
    xfer(1'b1, 8'h10, 32'h1);
    xfer(1'b1, 8'h1C, 32'h7);
    eng_u.frame(8'h60, 1'b1, 1'b1, 1'b1);
    rc(8'h00, fw(8'h60, 0));
    xfer(1'b1, 8'h10, 32'h1);
    xfer(1'b1, 8'h1C, 32'h6);
    $display("test own frames done");
    xfer(1'b1, 8'h14, 32'h7);
    xfer(1'b1, 8'h18, 32'h20);
    nx(1);
    chk(32'(tx_irq), 32'h0);
    eng_u.arb(4'h4);
    nx(1);
    chk(32'({tx_sel_valid, tx_sel}), 32'h5);
    chk(32'(tx_rd_byte), 32'hA5);
    chk(32'(ack_enable), 32'h0);
    eng_u.sent();
    nx(1);
    chk(32'(tx_irq), 32'h1);
    eng_u.arb(4'h0);
    nx(0);
    chk(32'(tx_sel), 32'h2);
    // Buffer 2 is on the bus, so only buffer 0 may be released
    xfer(1'b1, 8'h18, 32'h25);
    rc(8'h14, 32'h13);
    rc(8'h18, 32'h24);
    eng_u.sent();
    rc(8'h14, 32'h17);
    rc(8'h18, 32'h20);
    $display("test transmit done");
    eng_u.dom(1'b1);
    nx(3);
    chk(32'({can_tx_pin, rx_level}), 32'h0);
    eng_u.dom(1'b0);
    nx(3);
    chk(32'({can_tx_pin, rx_level}), 32'h3);
    $display("test pins done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    nx(1);
    chk(32'({tx_sel_valid, tx_irq, can_tx_pin}), 32'h1);
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rc(8'h14, 32'(EMPTY_RESET));
    rc(8'h20, 32'(LOCAL_PRIORITY_FIELD_RESET));
    $display("test second reset done");
    report_and_stop();
  end
endmodule : can_message_buffers_tb
